// >>> verilog/mms_decoder.sv
// Overview of operation
// - Short data: 16-bit values, base supplies address top
// - Long data: 24-bit values, addresses used directly
// - Short stream: ambiguous immediates fetch two bytes
// - Long stream: ambiguous immediates fetch three bytes
// - Fixed-length instructions ignore the stream part
// - Overrides never alter the persistent mode bit
// - Compatibility, no override: two bytes, upper undefined
// - Long stream, short data: keep lower sixteen bits
// - Long data, short stream: upper byte zero
// - Stream and data parts act independently
// - Full override ignores the persistent mode bit
// - Mode bit set: 24-bit; clear: 16-bit with base
// - Prefixes 40h, 49h, 52h recognised before instructions
module mms_decoder (
  input  wire logic                      clk,              // 125 MHz clock
  input  wire logic                      sys_rst,          // Asynchronous reset, active high
  // Instruction byte stream from program memory
  input  wire logic                      byte_valid,       // Byte offered
  input  wire logic [7:0]                byte_data,        // Prefix, opcode or immediate byte
  output logic                           byte_ready,       // Byte taken when valid and ready
  input  wire logic                      op_imm_ambiguous, // Opcode immediate length follows mode
  input  wire logic [1:0]                op_imm_fixed_len, // Immediate bytes of a fixed-length opcode
  input  wire logic [23:0]               ptr_value,        // pointer_pair, sampled with the opcode
  // Per-instruction result
  output logic                           instr_done,       // One-cycle pulse, results valid
  output logic                           data_long,        // Data path ran 24-bit
  output logic                           stream_long,      // Control path ran extended
  output logic [1:0]                     imm_len,          // Immediate bytes fetched
  output logic [23:0]                    imm_value,        // Immediate as fetched
  output logic [23:0]                    load_value,       // Destination register value
  output logic                           upper_defined,    // Upper byte of load_value defined
  output logic [23:0]                    mem_addr,         // Address formed for memory access
  output logic                           base_used,        // Address top came from the base
  // AXI4-Lite slave
  input  wire logic [mms_pkg::ADDR_W-1:0] s_axi_awaddr,    // Write address
  input  wire logic                      s_axi_awvalid,    // Write address valid
  output logic                           s_axi_awready,    // Write address ready
  input  wire logic [31:0]               s_axi_wdata,      // Write data
  input  wire logic [3:0]                s_axi_wstrb,      // Write byte lanes
  input  wire logic                      s_axi_wvalid,     // Write data valid
  output logic                           s_axi_wready,     // Write data ready
  output logic [1:0]                     s_axi_bresp,      // Write response
  output logic                           s_axi_bvalid,     // Write response valid
  input  wire logic                      s_axi_bready,     // Write response ready
  input  wire logic [mms_pkg::ADDR_W-1:0] s_axi_araddr,    // Read address
  input  wire logic                      s_axi_arvalid,    // Read address valid
  output logic                           s_axi_arready,    // Read address ready
  output logic [31:0]                    s_axi_rdata,      // Read data
  output logic [1:0]                     s_axi_rresp,      // Read response
  output logic                           s_axi_rvalid,     // Read data valid
  input  wire logic                      s_axi_rready      // Read data ready
);

  typedef struct packed {
    // Sequencer
    mms_pkg::mms_seq_t    seq;
    logic                 ovr_valid;
    logic                 ovr_data_long;
    logic                 ovr_stream_long;
    logic                 cur_data_long;
    logic                 cur_stream_long;
    logic [1:0]           len;
    logic [1:0]           cnt;
    logic [23:0]          imm;
    logic [23:0]          ptr;
    logic [31:0]          done_count;
    // Result outputs
    logic                 byte_ready;
    logic                 done;
    logic                 out_data_long;
    logic                 out_stream_long;
    logic [1:0]           out_len;
    logic [23:0]          out_imm;
    logic [23:0]          out_load;
    logic                 out_upper_def;
    logic [23:0]          out_addr;
    logic                 out_base_used;
    // Software registers
    logic                 ext_mode;
    logic [7:0]           base;
    // Bus slave
    logic                 aw_held;
    logic [mms_pkg::ADDR_W-1:0] aw_addr;
    logic                 w_held;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } mms_state_t;

  mms_state_t state_reg;
  mms_state_t state_next;

  logic        is_prefix;
  logic        pfx_data_long;
  logic        pfx_stream_long;
  logic        eff_data_long;
  logic        eff_stream_long;
  logic [23:0] form_load;
  logic        form_upper_def;
  logic [23:0] form_addr;
  logic        form_base_used;

  // Prefix decode and effective mode for the byte now offered
  mms_mode_resolve u_resolve (
    .byte_data       (byte_data),
    .ovr_valid       (state_reg.ovr_valid),
    .ovr_data_long   (state_reg.ovr_data_long),
    .ovr_stream_long (state_reg.ovr_stream_long),
    .ext_mode        (state_reg.ext_mode),
    .is_prefix       (is_prefix),
    .pfx_data_long   (pfx_data_long),
    .pfx_stream_long (pfx_stream_long),
    .data_long       (eff_data_long),
    .stream_long     (eff_stream_long)
  );

  // Result of the instruction once all immediate bytes are in
  mms_result_form u_form (
    .data_long     (state_reg.cur_data_long),
    // Fetched length, not the stream part, so fixed three-byte immediates stay whole
    .stream_long   (state_reg.len == mms_pkg::IMM_LEN_LONG),
    .imm           (state_reg.imm),
    .ptr           (state_reg.ptr),
    .base          (state_reg.base),
    .load_value    (form_load),
    .upper_defined (form_upper_def),
    .mem_addr      (form_addr),
    .base_used     (form_base_used)
  );

  // Full address match, so aliases above the map answer as unmapped
  function automatic logic addr_is(input logic [mms_pkg::ADDR_W-1:0] addr,
                                   input logic [mms_pkg::ADDR_W-1:0] offset);
    addr_is = (addr == offset);
  endfunction

  // Merge one byte lane of a write into an old byte
  function automatic logic [7:0] lane_merge(input logic [7:0] old_byte,
                                            input logic [7:0] new_byte,
                                            input logic       strobe);
    lane_merge = strobe ? new_byte : old_byte;
  endfunction

  // Immediate count: fixed opcodes take their own, ambiguous ones follow the stream part
  function automatic logic [1:0] imm_count(input logic ambiguous,
                                           input logic [1:0] fixed_len,
                                           input logic stream_is_long);
    if (!ambiguous)
      imm_count = fixed_len;
    else
      imm_count = stream_is_long ? mms_pkg::IMM_LEN_LONG : mms_pkg::IMM_LEN_SHORT;
  endfunction

  // Whole next state of the block
  always_comb
  begin
    logic [7:0] ctrl_lane0;
    logic [7:0] ctrl_lane1;
    logic [1:0] new_len;
    ctrl_lane0     = 8'h00;
    ctrl_lane1     = 8'h00;
    new_len        = 2'h0;
    state_next     = state_reg;
    state_next.done = 1'b0;

    // Instruction sequencer
    unique case (state_reg.seq)
      mms_pkg::SEQ_OPCODE :
      begin
        if (byte_valid && state_reg.byte_ready)
        begin
          if (is_prefix)
          begin
            // A later prefix replaces an earlier one for the same instruction
            state_next.ovr_valid       = 1'b1;
            state_next.ovr_data_long   = pfx_data_long;
            state_next.ovr_stream_long = pfx_stream_long;
          end
          else
          begin
            new_len                    = imm_count(op_imm_ambiguous, op_imm_fixed_len, eff_stream_long);
            state_next.cur_data_long   = eff_data_long;
            state_next.cur_stream_long = eff_stream_long;
            state_next.len             = new_len;
            state_next.cnt             = 2'h0;
            state_next.imm             = 24'h000000;
            state_next.ptr             = ptr_value;
            state_next.seq             = (new_len == mms_pkg::IMM_LEN_NONE) ? mms_pkg::SEQ_DONE
                                                                            : mms_pkg::SEQ_IMM;
          end
        end
      end
      mms_pkg::SEQ_IMM :
      begin
        if (byte_valid && state_reg.byte_ready)
        begin
          // Immediates arrive low byte first
          state_next.imm[{state_reg.cnt, 3'b000} +: 8] = byte_data;
          state_next.cnt = state_reg.cnt + 2'h1;
          if (state_reg.cnt + 2'h1 == state_reg.len)
            state_next.seq = mms_pkg::SEQ_DONE;
        end
      end
      mms_pkg::SEQ_DONE :
      begin
        // Publish the result and retire the override with its instruction
        state_next.done            = 1'b1;
        state_next.out_data_long   = state_reg.cur_data_long;
        state_next.out_stream_long = state_reg.cur_stream_long;
        state_next.out_len         = state_reg.len;
        state_next.out_imm         = state_reg.imm;
        state_next.out_load        = form_load;
        state_next.out_upper_def   = form_upper_def;
        state_next.out_addr        = form_addr;
        state_next.out_base_used   = form_base_used;
        state_next.ovr_valid       = 1'b0;
        state_next.done_count      = state_reg.done_count + 32'h1;
        state_next.seq             = mms_pkg::SEQ_OPCODE;
      end
    endcase
    // No byte is taken while a result is being published
    state_next.byte_ready = (state_next.seq != mms_pkg::SEQ_DONE);

    // Write channel: address and data are taken in either order
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;
    if (state_reg.awready && s_axi_awvalid)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (state_reg.wready && s_axi_wvalid)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_next.aw_held && state_next.w_held && !state_reg.bvalid)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = mms_pkg::RESP_OKAY;
      if (addr_is(state_next.aw_addr, mms_pkg::ADDR_CTRL))
      begin
        // Only software writes the persistent mode bit; overrides never do
        ctrl_lane0 = lane_merge({7'h00, state_reg.ext_mode}, state_next.w_data[7:0], state_next.w_strb[0]);
        ctrl_lane1 = lane_merge(state_reg.base, state_next.w_data[15:8], state_next.w_strb[1]);
        state_next.ext_mode = ctrl_lane0[mms_pkg::CTRL_EXT_BIT];
        state_next.base     = ctrl_lane1;
      end
      else if (!addr_is(state_next.aw_addr, mms_pkg::ADDR_STATUS) &&
               !addr_is(state_next.aw_addr, mms_pkg::ADDR_COUNT))
        state_next.bresp = mms_pkg::RESP_SLVERR;
    end
    state_next.awready = !state_next.aw_held;
    state_next.wready  = !state_next.w_held;

    // Read channel: one read at a time, data registered with valid
    if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid  = 1'b0;
      state_next.arready = 1'b1;
    end
    if (state_reg.arready && s_axi_arvalid)
    begin
      state_next.arready = 1'b0;
      state_next.rvalid  = 1'b1;
      state_next.rresp   = mms_pkg::RESP_OKAY;
      state_next.rdata   = 32'h00000000;
      if (addr_is(s_axi_araddr, mms_pkg::ADDR_CTRL))
      begin
        state_next.rdata[mms_pkg::CTRL_EXT_BIT]                 = state_reg.ext_mode;
        state_next.rdata[mms_pkg::CTRL_BASE_LSB +: 8]           = state_reg.base;
      end
      else if (addr_is(s_axi_araddr, mms_pkg::ADDR_STATUS))
      begin
        state_next.rdata[mms_pkg::STAT_PENDING_BIT]             = state_reg.ovr_valid;
        state_next.rdata[mms_pkg::STAT_DLONG_BIT]               = state_reg.out_data_long;
        state_next.rdata[mms_pkg::STAT_SLONG_BIT]               = state_reg.out_stream_long;
        state_next.rdata[mms_pkg::STAT_IMM_LSB +: 24]           = state_reg.out_imm;
      end
      else if (addr_is(s_axi_araddr, mms_pkg::ADDR_COUNT))
        state_next.rdata = state_reg.done_count;
      else
        state_next.rresp = mms_pkg::RESP_SLVERR;
    end
  end

  // State register; every field has a constant reset value
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg            <= '0;
      state_reg.seq        <= mms_pkg::SEQ_OPCODE;
      state_reg.byte_ready <= 1'b1;
      state_reg.ext_mode   <= mms_pkg::CTRL_EXT_RESET;
      state_reg.base       <= mms_pkg::CTRL_BASE_RESET;
      state_reg.awready    <= 1'b1;
      state_reg.wready     <= 1'b1;
      state_reg.arready    <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // Outputs straight from the state register
  assign byte_ready    = state_reg.byte_ready;
  assign instr_done    = state_reg.done;
  assign data_long     = state_reg.out_data_long;
  assign stream_long   = state_reg.out_stream_long;
  assign imm_len       = state_reg.out_len;
  assign imm_value     = state_reg.out_imm;
  assign load_value    = state_reg.out_load;
  assign upper_defined = state_reg.out_upper_def;
  assign mem_addr      = state_reg.out_addr;
  assign base_used     = state_reg.out_base_used;
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready  = state_reg.wready;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;

endmodule

// >>> verilog/mms_pkg.sv
package mms_pkg;

  // Override prefix bytes that may stand ahead of an instruction
  localparam logic [7:0] PFX_SHORT_DATA_SHORT_STREAM = 8'h40;
  localparam logic [7:0] PFX_LONG_DATA_SHORT_STREAM  = 8'h49;
  localparam logic [7:0] PFX_SHORT_DATA_LONG_STREAM  = 8'h52;

  // Immediate byte counts: short and long for ambiguous length, none for no immediate
  localparam logic [1:0] IMM_LEN_SHORT = 2'h2;
  localparam logic [1:0] IMM_LEN_LONG  = 2'h3;
  localparam logic [1:0] IMM_LEN_NONE  = 2'h0;

  // Upper byte written when a long register is loaded from a short stream
  localparam logic [7:0] UPPER_BYTE_ZERO = 8'h00;

  // Register map, byte addresses
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;

  // Control register fields and reset values
  localparam int         CTRL_EXT_BIT    = 0;
  localparam int         CTRL_BASE_LSB   = 8;
  localparam logic       CTRL_EXT_RESET  = 1'b0;
  localparam logic [7:0] CTRL_BASE_RESET = 8'h00;

  // Status register fields
  localparam int STAT_PENDING_BIT = 0;
  localparam int STAT_DLONG_BIT   = 1;
  localparam int STAT_SLONG_BIT   = 2;
  localparam int STAT_IMM_LSB     = 8;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Instruction sequencer states
  typedef enum logic [1:0] {
    SEQ_OPCODE,
    SEQ_IMM,
    SEQ_DONE
  } mms_seq_t;

endpackage

// >>> verilog/mms_mode_resolve.sv
module mms_mode_resolve (
  input  wire logic [7:0] byte_data,       // Byte offered by program memory
  input  wire logic       ovr_valid,       // An override is pending
  input  wire logic       ovr_data_long,   // Pending override data part is long
  input  wire logic       ovr_stream_long, // Pending override stream part is long
  input  wire logic       ext_mode,        // Persistent extended_address_mode bit
  output logic            is_prefix,       // Byte is an override prefix
  output logic            pfx_data_long,   // Prefix data part is long
  output logic            pfx_stream_long, // Prefix stream part is long
  output logic            data_long,       // Effective data path mode
  output logic            stream_long      // Effective control path mode
);

  // Prefix classification
  always_comb
  begin
    is_prefix       = 1'b1;
    pfx_data_long   = 1'b0;
    pfx_stream_long = 1'b0;
    unique case (byte_data)
      mms_pkg::PFX_SHORT_DATA_SHORT_STREAM : ;
      mms_pkg::PFX_LONG_DATA_SHORT_STREAM  : pfx_data_long = 1'b1;
      mms_pkg::PFX_SHORT_DATA_LONG_STREAM  : pfx_stream_long = 1'b1;
      default                              : is_prefix = 1'b0;
    endcase
  end

  // Override parts act independently; without one the persistent bit rules
  assign data_long   = ovr_valid ? ovr_data_long : ext_mode;
  assign stream_long = ovr_valid ? ovr_stream_long : ext_mode;

endmodule

// >>> verilog/mms_result_form.sv
module mms_result_form (
  input  wire logic        data_long,     // Data path in 24-bit mode
  input  wire logic        stream_long,   // Three immediate bytes were fetched
  input  wire logic [23:0] imm,           // Assembled immediate value
  input  wire logic [23:0] ptr,           // pointer_pair value of the instruction
  input  wire logic [7:0]  base,          // upper_address_base
  output logic      [23:0] load_value,    // Value for the destination register
  output logic             upper_defined, // Upper byte of load_value is meaningful
  output logic      [23:0] mem_addr,      // Memory address formed
  output logic             base_used      // Upper address byte came from the base
);

  // Long data keeps 24 bits; a two-byte fetch leaves the upper byte zero
  always_comb
  begin
    if (data_long)
    begin
      load_value    = {stream_long ? imm[23:16] : mms_pkg::UPPER_BYTE_ZERO, imm[15:0]};
      upper_defined = 1'b1;
      mem_addr      = ptr;
      base_used     = 1'b0;
    end
    else
    begin
      // Short data drops fetched upper bits; the byte is undefined to software
      load_value    = {mms_pkg::UPPER_BYTE_ZERO, imm[15:0]};
      upper_defined = 1'b0;
      mem_addr      = {base, ptr[15:0]};
      base_used     = 1'b1;
    end
  end

endmodule

// >>> verification/mms_decoder_asserts.sv
module mms_decoder_asserts (
  input wire logic        clk,           // Clock
  input wire logic        sys_rst,       // Reset
  input wire logic        byte_ready,    // Byte ready
  input wire logic        instr_done,    // Done pulse
  input wire logic        data_long,     // Data mode
  input wire logic [1:0]  imm_len,       // Bytes fetched
  input wire logic [23:0] imm_value,     // Immediate
  input wire logic [23:0] load_value,    // Loaded value
  input wire logic        upper_defined, // Upper byte valid
  input wire logic        base_used,     // Base used
  input wire logic        s_axi_arvalid, // Read addr valid
  input wire logic        s_axi_arready, // Read addr ready
  input wire logic        s_axi_rvalid,  // Read valid
  input wire logic        s_axi_rready,  // Read ready
  input wire logic [31:0] s_axi_rdata    // Read data
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Read steps: address taken, then data held until taken
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_held;
    s_axi_rvalid && $stable(s_axi_rdata);
  endsequence
  a_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("done pulse too long");
  a_ready_gap: assert property (instr_done |-> byte_ready && !$past(byte_ready))
    else $error("no one-cycle stall before done");
  a_base_short: assert property (instr_done |-> base_used == !data_long)
    else $error("base use does not follow data mode");
  a_short_upper: assert property (instr_done && !data_long |-> !upper_defined && load_value[23:16] == 8'h00)
    else $error("short data upper byte wrong");
  a_long_full: assert property (instr_done && data_long |-> upper_defined && load_value == imm_value)
    else $error("long data load not full");
  a_imm_upper: assert property (instr_done && imm_len != 2'h3 |-> imm_value[23:16] == 8'h00)
    else $error("unfetched byte not zero");
  a_load_low: assert property (instr_done |-> load_value[15:0] == imm_value[15:0])
    else $error("low bytes lost");
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> r_held)
    else $error("read data dropped");
endmodule

bind mms_decoder mms_decoder_asserts chk (.clk, .sys_rst, .byte_ready, .instr_done, .data_long, .imm_len,
  .imm_value, .load_value, .upper_defined, .base_used, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata);

// >>> verification/mms_prog_mem.sv
module mms_prog_mem (
  input  wire logic   clk,              // Clock
  input  wire logic   sys_rst,          // Reset
  input  wire logic   byte_ready,       // Decoder takes byte
  output logic        byte_valid,       // Byte offered
  output logic [7:0]  byte_data,        // Byte value
  output logic        op_imm_ambiguous, // Length follows mode
  output logic [1:0]  op_imm_fixed_len, // Fixed byte count
  output logic [23:0] ptr_value         // pointer_pair
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [34:0] q[$];
  logic        slow;
  int          rp;
  int          nr;
  // Entries are {ambiguous, fixed len, pointer, byte}
  task put(input logic [34:0] e);
    q.push_back(e);
  endtask
  // Idle or stalled lines carry junk so a stale byte is never reused
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      byte_valid <= 1'b0;
      {op_imm_ambiguous, op_imm_fixed_len, ptr_value, byte_data} <= 35'h0;
      rp = 0;
    end
    else
    begin
      nr = rp + int'(byte_valid && byte_ready);
      if (nr < q.size() && !(slow && nr != rp))
      begin
        byte_valid <= 1'b1;
        {op_imm_ambiguous, op_imm_fixed_len, ptr_value, byte_data} <= q[nr];
      end
      else
      begin
        byte_valid <= 1'b0;
        byte_data <= ~byte_data;
        ptr_value <= ~ptr_value;
      end
      rp = nr;
    end
endmodule

// >>> verification/mms_decoder_tb.sv
module mms_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, byte_valid, byte_ready, op_imm_ambiguous, instr_done, data_long, stream_long;
  logic upper_defined, base_used, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  byte_data, s_axi_awaddr, s_axi_araddr;
  logic [1:0]  op_imm_fixed_len, imm_len, s_axi_bresp, s_axi_rresp, rsp;
  logic [23:0] ptr_value, imm_value, load_value, mem_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  int          err_count, comparisons, cyc;
  logic [7:0]  pf [4] = '{8'h00, mms_pkg::PFX_SHORT_DATA_SHORT_STREAM, mms_pkg::PFX_LONG_DATA_SHORT_STREAM,
                          mms_pkg::PFX_SHORT_DATA_LONG_STREAM};

  mms_decoder uut (.*);
  mms_prog_mem mem (.*);

  always #4 clk = ~clk;
  // Hang guard: the whole run needs well under this
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      test_done();
    end
  end

  task test_done;
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bus writes release each channel at its own handshake
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axi_rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One instruction; prefix 49 also sent after 40 so the last prefix must win
  task run(input int p, input logic a, input logic e);
    logic dl, sl;
    logic [1:0] n;
    logic [23:0] im;
    dl = (p == 0) ? e : (p == 2);
    sl = (p == 0) ? e : (p == 3);
    n = a ? (sl ? mms_pkg::IMM_LEN_LONG : mms_pkg::IMM_LEN_SHORT) : {e, 1'b1};
    im = (n == 2'h3) ? 24'h123456 : (n == 2'h2) ? 24'h003456 : 24'h000056;
    @(negedge clk);
    if (p == 2) mem.put({27'h0, pf[1]});
    if (p != 0) mem.put({27'h0, pf[p]});
    mem.put({a, e, 1'b1, 24'h9abcde, 8'hc3});
    for (int k = 0; k < n; k++) mem.put({27'h0, im[8*k +: 8]});
    do @(posedge clk); while (instr_done !== 1'b1);
    chk("result", {dl, sl, n, im, dl ? im : {8'h00, im[15:0]}, dl, dl ? 24'h9abcde : 24'ha5bcde, !dl},
        {data_long, stream_long, imm_len, imm_value, load_value, upper_defined, mem_addr, base_used});
  endtask

  initial
  begin
    {clk, sys_rst} = 2'b01;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    mem.slow = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int e = 0; e < 2; e++)
    begin
      axi_wr(mms_pkg::ADDR_CTRL, {16'h0, 8'ha5, 7'h0, e[0]});
      mem.slow = e[0];
      for (int a = 0; a < 2; a++)
        for (int p = 0; p < 4; p++)
          run(p, a[0], e[0]);
      axi_rd(mms_pkg::ADDR_CTRL);
      chk("ctrl", {8'ha5, 7'h0, e[0]}, rd);
      axi_rd(mms_pkg::ADDR_STATUS);
      chk("pending", 1'b0, rd[0]);
    end
    axi_rd(mms_pkg::ADDR_COUNT);
    chk("count", 32'h10, rd);
    axi_rd(8'h0c);
    chk("unmapped", {mms_pkg::RESP_SLVERR, 32'h0}, {rsp, rd});
    axi_wr(mms_pkg::ADDR_STATUS, 32'hffffffff);
    chk("ro write", mms_pkg::RESP_OKAY, rsp);
    s_axi_wstrb <= 4'h2;
    axi_wr(mms_pkg::ADDR_CTRL, 32'h00003c00);
    axi_rd(mms_pkg::ADDR_CTRL);
    chk("lane merge", 32'h00003c01, rd);
    test_done();
  end
endmodule
